/* design/bcdtc_pkg.sv */
// shared constants, field layouts and carrier types of the bcd time and calendar counters
package bcdtc_pkg;

    // register addresses of the counter chain
    localparam logic [7:0] BCDTC_ADDR_SEC   = 8'h03;
    localparam logic [7:0] BCDTC_ADDR_MIN   = 8'h04;
    localparam logic [7:0] BCDTC_ADDR_HOUR  = 8'h05;
    localparam logic [7:0] BCDTC_ADDR_DAY   = 8'h06;
    localparam logic [7:0] BCDTC_ADDR_WDAY  = 8'h07;
    localparam logic [7:0] BCDTC_ADDR_MON   = 8'h08;
    localparam logic [7:0] BCDTC_ADDR_YEAR  = 8'h09;

    // reset values
    localparam logic [7:0] BCDTC_RST_SEC    = 8'h80;
    localparam logic [7:0] BCDTC_RST_MIN    = 8'h00;
    localparam logic [7:0] BCDTC_RST_HOUR   = 8'h00;
    localparam logic [7:0] BCDTC_RST_DAY    = 8'h01;
    localparam logic [7:0] BCDTC_RST_WDAY   = 8'h00;
    localparam logic [7:0] BCDTC_RST_MON    = 8'h01;
    localparam logic [7:0] BCDTC_RST_YEAR   = 8'h00;

    // implemented bits of each register, the rest read as zero except seconds bit 7, which reads back as osc_stop_flag
    localparam logic [7:0] BCDTC_MASK_SEC   = 8'h7F;
    localparam logic [7:0] BCDTC_MASK_MIN   = 8'h7F;
    localparam logic [7:0] BCDTC_MASK_HOUR  = 8'h3F;
    localparam logic [7:0] BCDTC_MASK_DAY   = 8'h3F;
    localparam logic [7:0] BCDTC_MASK_WDAY  = 8'h07;
    localparam logic [7:0] BCDTC_MASK_MON   = 8'h1F;
    localparam logic [7:0] BCDTC_MASK_YEAR  = 8'hFF;

    // field positions
    localparam int         BCDTC_OSC_STOP_BIT = 7;
    localparam int         BCDTC_MERIDIEM_BIT = 5;
    localparam int         BCDTC_DISABLE_BIT  = 7;

    // counting limits, bcd coded
    localparam logic [7:0] BCDTC_ZERO       = 8'h00;
    localparam logic [7:0] BCDTC_ONE        = 8'h01;
    localparam logic [7:0] BCDTC_SEC_MAX    = 8'h59;
    localparam logic [7:0] BCDTC_HOUR24_MAX = 8'h23;
    localparam logic [7:0] BCDTC_HOUR12_MAX = 8'h12;
    localparam logic [7:0] BCDTC_HOUR12_PRE = 8'h11;
    localparam logic [7:0] BCDTC_MON_MAX    = 8'h12;
    localparam logic [7:0] BCDTC_YEAR_MAX   = 8'h99;
    localparam logic [2:0] BCDTC_WDAY_MAX   = 3'h6;

    // month codes and month lengths
    localparam logic [7:0] BCDTC_MON_FEB    = 8'h02;
    localparam logic [7:0] BCDTC_MON_APR    = 8'h04;
    localparam logic [7:0] BCDTC_MON_JUN    = 8'h06;
    localparam logic [7:0] BCDTC_MON_SEP    = 8'h09;
    localparam logic [7:0] BCDTC_MON_NOV    = 8'h11;
    localparam logic [7:0] BCDTC_DAYS_28    = 8'h28;
    localparam logic [7:0] BCDTC_DAYS_29    = 8'h29;
    localparam logic [7:0] BCDTC_DAYS_30    = 8'h30;
    localparam logic [7:0] BCDTC_DAYS_31    = 8'h31;

    // host access request, from the serial interface logic on clk_sys
    typedef struct packed {
        logic       access_active;  // access in progress
        logic       wr;             // write strobe, one cycle
        logic [7:0] addr;           // register address
        logic [7:0] wdata;          // write data
    } bcdtc_req_type;

    // alarm fields, bit 7 of each is alarm_compare_disable
    typedef struct packed {
        logic [7:0] second;
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] weekday;
    } bcdtc_alarm_type;

    // whole state of the counter block
    typedef struct packed {
        logic [7:0] sec;       // bit 7 is osc_stop_flag
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] mon;
        logic [7:0] year;
        logic       pending;   // one deferred tick
        logic       alarm_match_flag; // sticky alarm flag
        logic       match_q;   // match seen last cycle
        logic [7:0] rdata;     // read data register
    } bcdtc_state_type;

endpackage

/* design/bcdtc_bcd_step.sv */
// one bcd two-digit counter stage with wrap from hi back to lo
`timescale 1ns/1ps
module bcdtc_bcd_step
(
    input  wire logic [7:0] value,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    output logic      [7:0] result,
    output logic            wrap
);
    // bcd order matches binary order, so a plain compare finds the top
    always_comb
    begin
        wrap   = (value >= hi);
        result = value;
        if (wrap)
        begin
            // out-of-range values written by software also land on lo
            result = lo;
        end
        else if (value[3:0] >= 4'h9)
        begin
            result = {4'(value[7:4] + 4'h1), 4'h0};
        end
        else
        begin
            result = {value[7:4], 4'(value[3:0] + 4'h1)};
        end
    end
endmodule

/* design/bcdtc_counters.sv */
// bcd time and calendar counter chain with access freeze, deferred tick and alarm compare
`timescale 1ns/1ps
module bcdtc_counters
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire logic                     tick_1hz,
    input  wire logic                     fmt_12h,
    input  wire logic                     osc_stopped,
    input  wire logic                     alarm_flag_clear,
    input  wire bcdtc_pkg::bcdtc_req_type   req,
    input  wire bcdtc_pkg::bcdtc_alarm_type alarm,
    output logic                     [7:0] reg_rdata,
    output logic                          alarm_match_flag,
    output logic                          osc_stop_flag
);
    import bcdtc_pkg::*;

    bcdtc_state_type s;          // registered state
    bcdtc_state_type next_s;     // next state

    logic       do_inc;          // chain advances this cycle
    logic       c_min;           // carry into minutes
    logic       c_hour;          // carry into hours
    logic       c_day;           // carry into day and weekday
    logic       c_mon;           // carry into month
    logic       c_year;          // carry into year
    logic       hour_wrap;       // hours roll into the next day
    logic       at_eleven;       // 12h count sits at 11
    logic       wr_en;           // write accepted
    logic       match;           // all enabled alarm fields agree
    logic       any_enabled;     // at least one alarm field enabled
    logic [7:0] day_max;         // last day of current month

    logic [7:0] sec_nx, min_nx, h12_nx, h24_nx, day_nx, mon_nx, year_nx;
    logic       sec_w, min_w, h12_w, h24_w, day_w, mon_w, year_w;

    // leap test on a bcd year: even tens need units 0,4,8, odd tens 2,6
    function automatic logic is_leap(input logic [7:0] y);
        logic u;
        u = 1'b0;
        if (y[4] == 1'b0)
        begin
            u = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        else
        begin
            u = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return u;
    endfunction

    // month length, bcd coded
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] d;
        d = BCDTC_DAYS_31;
        if (m == BCDTC_MON_FEB)
        begin
            d = is_leap(y) ? BCDTC_DAYS_29 : BCDTC_DAYS_28;
        end
        else if ((m == BCDTC_MON_APR) || (m == BCDTC_MON_JUN) ||
                 (m == BCDTC_MON_SEP) || (m == BCDTC_MON_NOV))
        begin
            d = BCDTC_DAYS_30;
        end
        return d;
    endfunction

    // one alarm field: disabled fields agree by default
    function automatic logic field_hit(input logic [7:0] a, input logic [7:0] live, input logic [7:0] mask);
        return a[BCDTC_DISABLE_BIT] || ((a & mask) == (live & mask));
    endfunction

    assign day_max = month_days(s.mon, s.year);

    // chain stages, each a bcd wrap counter
    bcdtc_bcd_step u_sec
    (
        .value  ({1'b0, s.sec[6:0]}),
        .lo     (BCDTC_ZERO),
        .hi     (BCDTC_SEC_MAX),
        .result (sec_nx),
        .wrap   (sec_w)
    );
    bcdtc_bcd_step u_min
    (
        .value  (s.min),
        .lo     (BCDTC_ZERO),
        .hi     (BCDTC_SEC_MAX),
        .result (min_nx),
        .wrap   (min_w)
    );
    bcdtc_bcd_step u_h12
    (
        .value  ({3'b000, s.hour[4:0]}),
        .lo     (BCDTC_ONE),
        .hi     (BCDTC_HOUR12_MAX),
        .result (h12_nx),
        .wrap   (h12_w)
    );
    bcdtc_bcd_step u_h24
    (
        .value  ({2'b00, s.hour[5:0]}),
        .lo     (BCDTC_ZERO),
        .hi     (BCDTC_HOUR24_MAX),
        .result (h24_nx),
        .wrap   (h24_w)
    );
    bcdtc_bcd_step u_day
    (
        .value  (s.day),
        .lo     (BCDTC_ONE),
        .hi     (day_max),
        .result (day_nx),
        .wrap   (day_w)
    );
    bcdtc_bcd_step u_mon
    (
        .value  (s.mon),
        .lo     (BCDTC_ONE),
        .hi     (BCDTC_MON_MAX),
        .result (mon_nx),
        .wrap   (mon_w)
    );
    bcdtc_bcd_step u_year
    (
        .value  (s.year),
        .lo     (BCDTC_ZERO),
        .hi     (BCDTC_YEAR_MAX),
        .result (year_nx),
        .wrap   (year_w)
    );

    // next state: tick deferral, chain advance, host writes, reads, alarm
    always_comb
    begin
        next_s      = s;
        wr_en       = req.access_active && req.wr;
        // frozen while the host is in, a held tick fires right after
        do_inc      = !req.access_active && (tick_1hz || s.pending);
        next_s.pending = req.access_active ? (s.pending || tick_1hz) : 1'b0;
        at_eleven   = (s.hour[4:0] == BCDTC_HOUR12_PRE[4:0]);
        // 12h rolls to the next day at 11 pm going to 12 am
        hour_wrap   = fmt_12h ? (at_eleven && s.hour[BCDTC_MERIDIEM_BIT]) : h24_w;
        c_min       = do_inc && sec_w;
        c_hour      = c_min && min_w;
        c_day       = c_hour && hour_wrap;
        c_mon       = c_day && day_w;
        c_year      = c_mon && mon_w;

        if (do_inc)
        begin
            next_s.sec = {s.sec[BCDTC_OSC_STOP_BIT], sec_nx[6:0]};
        end
        if (c_min)
        begin
            next_s.min = min_nx & BCDTC_MASK_MIN;
        end
        if (c_hour)
        begin
            if (fmt_12h)
            begin
                // meridiem flips on the 11 to 12 step
                next_s.hour = {2'b00, s.hour[BCDTC_MERIDIEM_BIT] ^ at_eleven, h12_nx[4:0]};
            end
            else
            begin
                next_s.hour = h24_nx & BCDTC_MASK_HOUR;
            end
        end
        if (c_day)
        begin
            next_s.day  = day_nx & BCDTC_MASK_DAY;
            // saturday 110 wraps to sunday 000
            next_s.wday = (s.wday[2:0] >= BCDTC_WDAY_MAX) ? 8'h00 : {5'b00000, 3'(s.wday[2:0] + 3'h1)};
        end
        if (c_mon)
        begin
            next_s.mon = mon_nx & BCDTC_MASK_MON;
        end
        if (c_year)
        begin
            next_s.year = year_nx;
        end

        // host writes; unused bit positions are dropped
        if (wr_en)
        begin
            unique case (req.addr)
                BCDTC_ADDR_SEC:  next_s.sec  = req.wdata;
                BCDTC_ADDR_MIN:  next_s.min  = req.wdata & BCDTC_MASK_MIN;
                BCDTC_ADDR_HOUR: next_s.hour = req.wdata & BCDTC_MASK_HOUR;
                BCDTC_ADDR_DAY:  next_s.day  = req.wdata & BCDTC_MASK_DAY;
                BCDTC_ADDR_WDAY: next_s.wday = req.wdata & BCDTC_MASK_WDAY;
                BCDTC_ADDR_MON:  next_s.mon  = req.wdata & BCDTC_MASK_MON;
                BCDTC_ADDR_YEAR: next_s.year = req.wdata;
                default:         next_s.sec  = next_s.sec; // outside the chain
            endcase
        end
        // oscillator stop beats a software clear of the flag
        if (osc_stopped)
        begin
            next_s.sec[BCDTC_OSC_STOP_BIT] = 1'b1;
        end

        // read data registered, unmapped addresses read zero
        unique case (req.addr)
            BCDTC_ADDR_SEC:  next_s.rdata = s.sec;
            BCDTC_ADDR_MIN:  next_s.rdata = s.min & BCDTC_MASK_MIN;
            BCDTC_ADDR_HOUR: next_s.rdata = s.hour & BCDTC_MASK_HOUR;
            BCDTC_ADDR_DAY:  next_s.rdata = s.day & BCDTC_MASK_DAY;
            BCDTC_ADDR_WDAY: next_s.rdata = s.wday & BCDTC_MASK_WDAY;
            BCDTC_ADDR_MON:  next_s.rdata = s.mon & BCDTC_MASK_MON;
            BCDTC_ADDR_YEAR: next_s.rdata = s.year;
            default:         next_s.rdata = 8'h00;
        endcase

        // alarm: every enabled field must agree with the live count
        any_enabled = !(alarm.second[BCDTC_DISABLE_BIT] && alarm.minute[BCDTC_DISABLE_BIT] &&
                        alarm.hour[BCDTC_DISABLE_BIT] && alarm.day[BCDTC_DISABLE_BIT] &&
                        alarm.weekday[BCDTC_DISABLE_BIT]);
        match = any_enabled &&
                field_hit(alarm.second,  s.sec,  BCDTC_MASK_SEC) &&
                field_hit(alarm.minute,  s.min,  BCDTC_MASK_MIN) &&
                field_hit(alarm.hour,    s.hour, BCDTC_MASK_HOUR) &&
                field_hit(alarm.day,     s.day,  BCDTC_MASK_DAY) &&
                field_hit(alarm.weekday, s.wday, BCDTC_MASK_WDAY);
        next_s.match_q = match;
        // a new match wins over a clear in the same cycle
        if (match && !s.match_q)
        begin
            next_s.alarm_match_flag = 1'b1;
        end
        else if (alarm_flag_clear)
        begin
            next_s.alarm_match_flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '{sec: BCDTC_RST_SEC, min: BCDTC_RST_MIN, hour: BCDTC_RST_HOUR, day: BCDTC_RST_DAY,
                   wday: BCDTC_RST_WDAY, mon: BCDTC_RST_MON, year: BCDTC_RST_YEAR,
                   pending: 1'b0, alarm_match_flag: 1'b0, match_q: 1'b0, rdata: 8'h00};
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata        = s.rdata;
    assign alarm_match_flag = s.alarm_match_flag;
    assign osc_stop_flag    = s.sec[BCDTC_OSC_STOP_BIT];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_tick_in_access;
        req.access_active && tick_1hz;
    endsequence
    sequence s_access_done;
        !req.access_active;
    endsequence
    // a tick held over from an access still waiting to be spent
    sequence s_held_tick;
        s.pending;
    endsequence

    // writes are the only way a frozen counter may move
    a_freeze_minutes: assert property ((req.access_active && !req.wr) |=> (s.min == $past(s.min)))
        else $error("minutes moved during a host access");
    a_freeze_calendar: assert property ((req.access_active && !req.wr) |=>
        (s.hour == $past(s.hour) && s.day == $past(s.day) && s.year == $past(s.year)))
        else $error("calendar moved during a host access");
    a_pending_held: assert property (s_tick_in_access |=> s.pending)
        else $error("tick during access was not held");
    // only one held tick: it is spent on the first free edge
    a_pending_apply: assert property ((s_held_tick ##0 s_access_done) |=>
        (s.sec != $past(s.sec) && !s.pending))
        else $error("held tick not applied after the access");
    a_sec_wrap: assert property ((do_inc && s.sec[6:0] == 7'h59) |=> (s.sec[6:0] == 7'h00))
        else $error("seconds did not wrap to 00");
    a_min_carry: assert property ((c_min && s.min == 8'h59) |=> (s.min == 8'h00))
        else $error("minutes did not wrap on carry");
    a_hour24_wrap: assert property ((c_hour && !fmt_12h && s.hour == 8'h23) |=> (s.hour == 8'h00))
        else $error("24 hour count did not wrap");
    a_meridiem_flip: assert property ((c_hour && fmt_12h && s.hour[4:0] == 5'h11) |=>
        (s.hour[5] != $past(s.hour[5]) && s.hour[4:0] == 5'h12))
        else $error("meridiem did not flip at 11 to 12");
    // 12 to 01 keeps the half of the day
    a_hour12_keep: assert property ((c_hour && fmt_12h && s.hour[4:0] == 5'h12) |=>
        (s.hour[5] == $past(s.hour[5]) && s.hour[4:0] == 5'h01))
        else $error("12 hour count did not step 12 to 01");
    a_leap_feb: assert property ((c_day && s.mon == 8'h02 && s.day == 8'h28 && is_leap(s.year)) |=>
        (s.day == 8'h29))
        else $error("leap february lost its 29th");
    a_day_wrap: assert property ((c_day && s.day >= day_max) |=> (s.day == 8'h01))
        else $error("day did not wrap to 01 after month end");
    a_week_wrap: assert property ((c_day && s.wday == 8'h06) |=> (s.wday == 8'h00))
        else $error("weekday did not wrap to sunday");
    a_year_carry: assert property ((c_mon && s.mon == 8'h12) |=> (s.mon == 8'h01 && s.year != $past(s.year)))
        else $error("december did not carry into the year");
    a_unused_zero: assert property ((s.min[7] == 1'b0) && (s.hour[7:6] == 2'b00) && (s.wday[7:3] == 5'h00))
        else $error("unused bit set in a counter");
    // set on the rising match only, then held until a clear
    a_alarm_sets: assert property ((match && !s.match_q) |=> s.alarm_match_flag)
        else $error("alarm flag not set on a new match");
    a_alarm_sticky: assert property ((s.alarm_match_flag && !alarm_flag_clear) |=> s.alarm_match_flag)
        else $error("alarm flag dropped without a clear");
    a_alarm_clear: assert property ((alarm_flag_clear && !(match && !s.match_q)) |=> !s.alarm_match_flag)
        else $error("alarm flag survived a clear");
    // a stopped oscillator outranks any seconds write
    a_osc_stop_force: assert property (osc_stopped |=> s.sec[BCDTC_OSC_STOP_BIT])
        else $error("oscillator stop did not raise the flag");
    // read data is the addressed register one edge later
    a_read_year: assert property ((req.addr == BCDTC_ADDR_YEAR) |=> (reg_rdata == $past(s.year)))
        else $error("year read back wrong");

endmodule

/* tb/bcdtc_host_model.sv */
// host side model that reaches the counter registers through the request struct
`timescale 1ns/1ps
module bcdtc_host_model
(
    input  wire logic               clk_sys,
    input  wire logic         [7:0] reg_rdata,
    output bcdtc_pkg::bcdtc_req_type req
);
    import bcdtc_pkg::*;

    // idle bus at time zero
    initial
    begin
        req = '0;
    end

    // one burst covers seconds through years and ends well inside one second
    task automatic open_access;
        @(posedge clk_sys);
        req.access_active <= 1'b1;
    endtask

    // release the freeze; data line is inverted, so after a write it shows the last byte again
    task automatic close_access;
        @(posedge clk_sys);
        req.access_active <= 1'b0;
        req.wdata         <= ~req.wdata;
    endtask

    // one-cycle strobe, data held until the taking edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk_sys);
        req.wr    <= 1'b0;
        req.wdata <= ~d;
    endtask

    // read data is registered, so it lands one edge after the address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        req.addr <= a;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule

/* tb/bcdtc_counters_tb.sv */
// self-checking bench of the bcd time and calendar counters
`timescale 1ns/1ps
`define BCDTC_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module bcdtc_counters_tb;
    import bcdtc_pkg::*;

    logic            clk_sys;          // 200 mhz system clock
    logic            rst_b;            // async reset, active low
    logic            tick_1hz;         // one-cycle second tick
    logic            fmt_12h;          // hour format select
    logic            osc_stopped;      // oscillator stop level
    logic            alarm_flag_clear; // clear pulse
    bcdtc_req_type   req;              // host request from model
    bcdtc_alarm_type alarm;            // alarm fields
    logic      [7:0] reg_rdata;        // read data
    logic            alarm_match_flag; // sticky alarm flag
    logic            osc_stop_flag;    // seconds bit 7
    int              n_mismatch;       // failed comparisons
    int              comparisons;      // all comparisons
    int              cycles;           // timeout counter

    // feb, month-end and digit-carry cases: year, month, day, next day, next month
    localparam logic [39:0] CAL [10] = '{40'h00_0228_2902, 40'h04_0229_0103, 40'h01_0228_0103,
        40'h10_0228_0103, 40'h12_0228_2902, 40'h21_0430_0105, 40'h21_0131_0102,
        40'h21_0109_1001, 40'h21_1130_0112, 40'h21_0930_0110};
    // hour in, hour out, day out; the last row runs in 24 hour format
    localparam logic [23:0] HRS [6] = '{24'h11_3205, 24'h32_2105, 24'h31_1206, 24'h12_0105,
        24'h09_1005, 24'h11_1205};

    bcdtc_counters dut (.clk_sys(clk_sys), .rst_b(rst_b), .tick_1hz(tick_1hz), .fmt_12h(fmt_12h),
        .osc_stopped(osc_stopped), .alarm_flag_clear(alarm_flag_clear), .req(req), .alarm(alarm),
        .reg_rdata(reg_rdata), .alarm_match_flag(alarm_match_flag), .osc_stop_flag(osc_stop_flag));

    bcdtc_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .req(req));

    // free-running clock, 5 ns period
    always #2.5 clk_sys = ~clk_sys;

    // a hang counts as a mismatch; whole run is under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // seconds through years in one burst, seconds in the top byte
    task automatic set_regs(input logic [55:0] v);
        host.open_access();
        for (int i = 0; i < 7; i++)
            host.write_reg(BCDTC_ADDR_SEC + 8'(i), v[55 - 8 * i -: 8]);
        host.close_access();
    endtask

    // read back all seven counters in one burst
    task automatic chk_regs(input logic [55:0] v);
        logic [7:0] d;
        host.open_access();
        for (int i = 0; i < 7; i++)
        begin
            host.read_reg(BCDTC_ADDR_SEC + 8'(i), d);
            `BCDTC_CHK($sformatf("reg %h", BCDTC_ADDR_SEC + 8'(i)), v[55 - 8 * i -: 8], d)
        end
        host.close_access();
    endtask

    // one tick, then time for the chain to settle
    task automatic pulse_tick;
        @(posedge clk_sys);
        tick_1hz <= 1'b1;
        @(posedge clk_sys);
        tick_1hz <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic t_reset;
        chk_regs({BCDTC_RST_SEC, BCDTC_RST_MIN, BCDTC_RST_HOUR, BCDTC_RST_DAY, BCDTC_RST_WDAY,
            BCDTC_RST_MON, BCDTC_RST_YEAR});
        #1;
        `BCDTC_CHK("osc stop flag", 1'b1, osc_stop_flag)
    endtask

    // unused bits drop, unmapped place reads zero
    task automatic t_unused;
        logic [7:0] d;
        set_regs({7{8'hFF}});
        chk_regs({8'hFF, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h1F, 8'hFF});
        host.open_access();
        host.write_reg(8'h0A, 8'h55);
        host.read_reg(8'h0A, d);
        host.close_access();
        `BCDTC_CHK("unmapped", 8'h00, d)
    endtask

    // every stage wraps at once, saturday back to sunday
    task automatic t_rollover;
        set_regs({8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99});
        pulse_tick();
        chk_regs({8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
    endtask

    // month lengths and leap years from the last second of a day
    task automatic t_calendar;
        for (int i = 0; i < 10; i++)
        begin
            set_regs({8'h59, 8'h59, 8'h23, CAL[i][23:16], 8'h00, CAL[i][31:24], CAL[i][39:32]});
            pulse_tick();
            chk_regs({8'h00, 8'h00, 8'h00, CAL[i][15:8], 8'h01, CAL[i][7:0], CAL[i][39:32]});
        end
    endtask

    // meridiem flips at 11 to 12, day and weekday carry only past 11 pm
    task automatic t_hours;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_sys);
            fmt_12h <= (i < 5);
            set_regs({8'h59, 8'h59, HRS[i][23:16], 8'h05, 8'h03, 8'h06, 8'h21});
            pulse_tick();
            chk_regs({8'h00, 8'h00, HRS[i][15:0], (HRS[i][7:0] == 8'h06) ? 8'h04 : 8'h03,
                8'h06, 8'h21});
        end
        @(posedge clk_sys);
        fmt_12h <= 1'b0;
    endtask

    // two ticks inside one access: counters hold, only one is applied later
    task automatic t_freeze;
        logic [7:0] d;
        set_regs({8'h00, 8'h30, 8'h10, 8'h15, 8'h02, 8'h07, 8'h33});
        host.open_access();
        pulse_tick();
        pulse_tick();
        host.read_reg(BCDTC_ADDR_SEC, d);
        `BCDTC_CHK("frozen sec", 8'h00, d)
        host.close_access();
        repeat (3) @(posedge clk_sys);
        chk_regs({8'h01, 8'h30, 8'h10, 8'h15, 8'h02, 8'h07, 8'h33});
    endtask

    // minute match, sticky clear, disabled field ignored, second match
    task automatic t_alarm;
        set_regs({8'h59, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
        @(posedge clk_sys);
        alarm.minute <= 8'h01;
        pulse_tick();
        #1;
        `BCDTC_CHK("alarm set", 1'b1, alarm_match_flag)
        @(posedge clk_sys);
        alarm_flag_clear <= 1'b1;
        @(posedge clk_sys);
        alarm_flag_clear <= 1'b0;
        alarm.minute     <= 8'h81;
        alarm.second     <= 8'h02;
        repeat (2) @(posedge clk_sys);
        #1;
        `BCDTC_CHK("alarm clear", 1'b0, alarm_match_flag)
        pulse_tick();
        #1;
        `BCDTC_CHK("no match", 1'b0, alarm_match_flag)
        pulse_tick();
        #1;
        `BCDTC_CHK("second match", 1'b1, alarm_match_flag)
    endtask

    // stop forces the flag, a seconds write clears it
    task automatic t_osc_stop;
        logic [7:0] d;
        @(posedge clk_sys);
        osc_stopped <= 1'b1;
        @(posedge clk_sys);
        osc_stopped <= 1'b0;
        host.open_access();
        host.read_reg(BCDTC_ADDR_SEC, d);
        `BCDTC_CHK("sec bit 7", 1'b1, d[7])
        `BCDTC_CHK("stop flag", 1'b1, osc_stop_flag)
        host.write_reg(BCDTC_ADDR_SEC, 8'h00);
        host.close_access();
        #1;
        `BCDTC_CHK("flag cleared", 1'b0, osc_stop_flag)
    endtask

    // reset for eight cycles, then the scenarios
    initial
    begin
        clk_sys          = 1'b0;
        rst_b            = 1'b0;
        tick_1hz         = 1'b0;
        fmt_12h          = 1'b0;
        osc_stopped      = 1'b0;
        alarm_flag_clear = 1'b0;
        alarm            = '{default: 8'h80};
        n_mismatch       = 0;
        comparisons      = 0;
        cycles           = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_unused();
        t_rollover();
        t_calendar();
        t_hours();
        t_freeze();
        t_alarm();
        t_osc_stop();
        print_verdict();
    end
endmodule
